/* File: common/bridge_window_params.svh */
`ifndef BRIDGE_WINDOW_PARAMS_SVH
`define BRIDGE_WINDOW_PARAMS_SVH

// ------------------------------------------------------------
// configuration space byte offsets
// ------------------------------------------------------------
`define MEM_BOTTOM_OFS 8'h20
`define MEM_TOP_OFS 8'h22
`define PREF_BOTTOM_OFS 8'h24
`define PREF_TOP_OFS 8'h26
`define PREF_BASE_HIGH_OFS 8'h28
`define PREF_TOP_HIGH_OFS 8'h2c

// ------------------------------------------------------------
// field positions within a 16-bit window register
// ------------------------------------------------------------
`define WINDOW_FIELD_MSB 15
`define WINDOW_FIELD_LSB 4
`define WINDOW_LOW_BITS 20

// ------------------------------------------------------------
// reset and fixed values
// ------------------------------------------------------------
`define MEM_WINDOW_RESET 16'h0000
`define PREF_WINDOW_RESET 16'h0001
`define PREF_HIGH_RESET 32'h0000_0000
`define WIDE_ADDR_CODE 4'h1
`define UNUSED_BITS_VALUE 4'h0
`define IMPLIED_LOW_ZEROS 20'h0_0000
`define IMPLIED_LOW_ONES 20'hf_ffff

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define DECODE_LATENCY_CYCLES 1

`endif

/* File: common/bridge_window_pkg.sv */
package bridge_window_pkg;

  typedef logic [11:0] window_field_type;
  typedef logic [31:0] dword_type;
  typedef logic [63:0] wide_addr_type;
  typedef logic [1:0] lane_pair_type;

endpackage : bridge_window_pkg

/* File: logic/bridge_memory_window_decode.sv */
`timescale 1ns/1ps
`include "bridge_window_params.svh"

// Functional notes
// RL1 - memory top bits 15:4 give limit address bits 31:20; low 20 bits are ones
// RL2 - memory top bits 3:0 read zero; writes to them are ignored
// RL3 - prefetch base bits 15:4 give base address bits 31:20; low bits zero
// RL4 - prefetch top bits 15:4 give limit address bits 31:20; low bits ones
// RL5 - prefetch base and top bits 3:0 read 0001, marking 64-bit support
// RL6 - writable 32-bit register holds prefetch base bits 63:32, resets zero
// RL7 - register at 2Ch holds prefetch limit bits 63:32 for the compare
// RL8 - base and limit of each window decide which memory cycles forward
// RL9 - memory top register reads zero after reset, limit field cleared
// RL10 - memory base bits 15:4 give base address bits 31:20; low bits zero
// RL11 - match when base <= address <= limit; inverted window forwards nothing
module bridge_memory_window_decode
  import bridge_window_pkg::*;
#(
  parameter int ADDR_W = 64
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  output logic cfg_claim,
  input wire logic txn_valid,
  input wire logic txn_mem,
  input wire logic [ADDR_W-1:0] txn_addr,
  output logic dec_valid,
  output logic dec_forward,
  output logic dec_mem_hit,
  output logic dec_pref_hit
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (ADDR_W < 32 || ADDR_W > 64) begin : g_bad_width
    $error("ADDR_W must lie between 32 and 64");
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // dword slot of a byte offset; config cycles are dword wide
  function automatic logic [5:0] slot_of(input logic [7:0] ofs);
    slot_of = ofs[7:2];
  endfunction : slot_of

  // merge one 16-bit half into a 12-bit field under its two lanes;
  // bits 3:0 of the half belong to no storage and are dropped
  function automatic window_field_type merge_field(
    input window_field_type old,
    input logic [15:0] data,
    input lane_pair_type lanes
  );
    merge_field = old;
    if (lanes[0]) begin
      merge_field[3:0] = data[7:`WINDOW_FIELD_LSB];
    end
    if (lanes[1]) begin
      merge_field[11:4] = data[`WINDOW_FIELD_MSB:8];
    end
  endfunction : merge_field

  // byte-lane merge for the full 32-bit upper registers
  function automatic dword_type merge_word(
    input dword_type old,
    input dword_type data,
    input logic [3:0] lanes
  );
    merge_word = old;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        merge_word[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction : merge_word

  // inclusive range compare; an inverted window never matches
  function automatic logic in_window(
    input wide_addr_type addr,
    input wide_addr_type lo,
    input wide_addr_type hi
  );
    in_window = (lo <= addr) && (addr <= hi); // RL11
  endfunction : in_window

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  window_field_type mem_window_bottom_field_r;
  window_field_type mem_window_top_field_r;
  window_field_type prefetch_bottom_field_r;
  window_field_type prefetch_top_field_r;
  dword_type prefetch_window_base_high_r;
  dword_type prefetch_window_top_high_r;

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  logic [5:0] slot;
  logic wr_mem_slot;
  logic wr_pref_slot;
  logic wr_base_high;
  logic wr_top_high;
  logic slot_mapped;

  assign slot = slot_of(cfg_addr);

  always_comb begin
    wr_mem_slot = 1'b0;
    wr_pref_slot = 1'b0;
    wr_base_high = 1'b0;
    wr_top_high = 1'b0;
    slot_mapped = 1'b1;
    if (slot == slot_of(`MEM_BOTTOM_OFS)) begin
      wr_mem_slot = cfg_wr_en;
    end else if (slot == slot_of(`PREF_BOTTOM_OFS)) begin
      wr_pref_slot = cfg_wr_en;
    end else if (slot == slot_of(`PREF_BASE_HIGH_OFS)) begin
      wr_base_high = cfg_wr_en;
    end else if (slot == slot_of(`PREF_TOP_HIGH_OFS)) begin
      wr_top_high = cfg_wr_en;
    end else begin
      slot_mapped = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // non-prefetchable window fields
  // ------------------------------------------------------------
  // memory base sits in the low half of the dword at 20h
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mem_window_bottom_field_r <= '0;
    end else if (wr_mem_slot) begin
      mem_window_bottom_field_r <= merge_field(mem_window_bottom_field_r,
        cfg_wdata[15:0], cfg_byte_en[1:0]); // RL10
    end
  end

  // memory top sits in the high half, at byte offset 22h
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mem_window_top_field_r <= window_field_type'(`MEM_WINDOW_RESET >> `WINDOW_FIELD_LSB); // RL9
    end else if (wr_mem_slot) begin
      mem_window_top_field_r <= merge_field(mem_window_top_field_r,
        cfg_wdata[31:16], cfg_byte_en[3:2]); // RL1 RL2
    end
  end

  // ------------------------------------------------------------
  // prefetchable window fields
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prefetch_bottom_field_r <= window_field_type'(`PREF_WINDOW_RESET >> `WINDOW_FIELD_LSB);
    end else if (wr_pref_slot) begin
      prefetch_bottom_field_r <= merge_field(prefetch_bottom_field_r,
        cfg_wdata[15:0], cfg_byte_en[1:0]); // RL3
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prefetch_top_field_r <= window_field_type'(`PREF_WINDOW_RESET >> `WINDOW_FIELD_LSB);
    end else if (wr_pref_slot) begin
      prefetch_top_field_r <= merge_field(prefetch_top_field_r,
        cfg_wdata[31:16], cfg_byte_en[3:2]); // RL4
    end
  end

  // ------------------------------------------------------------
  // prefetchable upper address words
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prefetch_window_base_high_r <= `PREF_HIGH_RESET; // RL6
    end else if (wr_base_high) begin
      prefetch_window_base_high_r <= merge_word(prefetch_window_base_high_r,
        cfg_wdata, cfg_byte_en); // RL6
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prefetch_window_top_high_r <= `PREF_HIGH_RESET;
    end else if (wr_top_high) begin
      prefetch_window_top_high_r <= merge_word(prefetch_window_top_high_r,
        cfg_wdata, cfg_byte_en); // RL7
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  dword_type rdata_nxt;

  // read of a slot written in the same cycle returns the old value
  always_comb begin
    rdata_nxt = '0;
    if (slot == slot_of(`MEM_BOTTOM_OFS)) begin
      rdata_nxt = {mem_window_top_field_r, `UNUSED_BITS_VALUE,
        mem_window_bottom_field_r, `UNUSED_BITS_VALUE}; // RL2
    end else if (slot == slot_of(`PREF_BOTTOM_OFS)) begin
      rdata_nxt = {prefetch_top_field_r, `WIDE_ADDR_CODE,
        prefetch_bottom_field_r, `WIDE_ADDR_CODE}; // RL5
    end else if (slot == slot_of(`PREF_BASE_HIGH_OFS)) begin
      rdata_nxt = prefetch_window_base_high_r;
    end else if (slot == slot_of(`PREF_TOP_HIGH_OFS)) begin
      rdata_nxt = prefetch_window_top_high_r;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata <= '0;
    end else if (cfg_rd_en) begin
      cfg_rdata <= rdata_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ack <= 1'b0;
      cfg_claim <= 1'b0;
    end else begin
      cfg_ack <= cfg_rd_en | cfg_wr_en;
      cfg_claim <= (cfg_rd_en | cfg_wr_en) & slot_mapped;
    end
  end

  // ------------------------------------------------------------
  // window bounds
  // ------------------------------------------------------------
  wide_addr_type mem_lo;
  wide_addr_type mem_hi;
  wide_addr_type pref_lo;
  wide_addr_type pref_hi;
  wide_addr_type txn_addr_wide;

  // the non-prefetchable window lives below 4 GiB only
  assign mem_lo = {32'h0, mem_window_bottom_field_r,
    `IMPLIED_LOW_ZEROS}; // RL10
  assign mem_hi = {32'h0, mem_window_top_field_r,
    `IMPLIED_LOW_ONES}; // RL1
  assign pref_lo = {prefetch_window_base_high_r, prefetch_bottom_field_r,
    `IMPLIED_LOW_ZEROS}; // RL3 RL6
  assign pref_hi = {prefetch_window_top_high_r, prefetch_top_field_r,
    `IMPLIED_LOW_ONES}; // RL4 RL7
  assign txn_addr_wide = 64'(txn_addr);

  // ------------------------------------------------------------
  // forwarding decision
  // ------------------------------------------------------------
  logic mem_hit_nxt;
  logic pref_hit_nxt;

  // registered so the wide compares get a full cycle to settle
  assign mem_hit_nxt = txn_mem & in_window(txn_addr_wide, mem_lo, mem_hi);
  assign pref_hit_nxt = txn_mem & in_window(txn_addr_wide, pref_lo, pref_hi);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= txn_valid;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dec_mem_hit <= 1'b0;
      dec_pref_hit <= 1'b0;
      dec_forward <= 1'b0;
    end else if (txn_valid) begin
      dec_mem_hit <= mem_hit_nxt; // RL8
      dec_pref_hit <= pref_hit_nxt; // RL8
      dec_forward <= mem_hit_nxt | pref_hit_nxt; // RL8 RL11
    end else begin
      dec_mem_hit <= 1'b0;
      dec_pref_hit <= 1'b0;
      dec_forward <= 1'b0;
    end
  end

endmodule : bridge_memory_window_decode

/* File: tb/bridge_window_assertions.sv */
`timescale 1ns/1ps
// ----
// port checks
// ----
module bridge_window_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack,
  input wire logic cfg_claim,
  input wire logic txn_valid,
  input wire logic txn_mem,
  input wire logic dec_valid,
  input wire logic dec_forward,
  input wire logic dec_mem_hit,
  input wire logic dec_pref_hit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_rd(slot);
    cfg_rd_en && cfg_addr[7:2] == slot;
  endsequence
  sequence s_access;
    cfg_rd_en || cfg_wr_en;
  endsequence
  property p_ack; s_access |=> cfg_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_no_ack; !(cfg_rd_en || cfg_wr_en) |=> !cfg_ack && !cfg_claim; endproperty
  a_no_ack: assert property (p_no_ack) else $error("stray ack");
  property p_mem_low; s_rd(6'h08) |=> cfg_claim && cfg_rdata[3:0] == 4'h0 && cfg_rdata[19:16] == 4'h0; endproperty
  a_mem_low: assert property (p_mem_low) else $error("unused bits not zero");
  property p_wide; s_rd(6'h09) |=> cfg_claim && cfg_rdata[3:0] == 4'h1 && cfg_rdata[19:16] == 4'h1; endproperty
  a_wide: assert property (p_wide) else $error("wide code wrong");
  property p_unmapped; s_rd(6'h0c) |=> cfg_ack && !cfg_claim && cfg_rdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_hold; !cfg_rd_en |=> $stable(cfg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_dec; txn_valid |=> dec_valid ##1 (!dec_valid || $past(txn_valid)); endproperty
  a_dec: assert property (p_dec) else $error("decode latency");
  property p_non_mem; txn_valid && !txn_mem |=> !dec_mem_hit && !dec_pref_hit; endproperty
  a_non_mem: assert property (p_non_mem) else $error("non memory hit");
  property p_fwd; (!dec_valid |-> !dec_forward) and (dec_valid |-> dec_forward == (dec_mem_hit || dec_pref_hit)); endproperty
  a_fwd: assert property (p_fwd) else $error("forward mismatch");
endmodule : bridge_window_checker

bind bridge_memory_window_decode bridge_window_checker u_bridge_window_checker (.clk_sys(clk_sys),
  .reset_n(reset_n), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
  .cfg_ack(cfg_ack), .cfg_claim(cfg_claim), .txn_valid(txn_valid), .txn_mem(txn_mem), .dec_valid(dec_valid),
  .dec_forward(dec_forward), .dec_mem_hit(dec_mem_hit), .dec_pref_hit(dec_pref_hit));

/* File: tb/txn_source_model.sv */
`timescale 1ns/1ps
// ----
// upstream requester
// ----
module txn_source_model (
  input wire logic clk_sys,
  output logic txn_valid,
  output logic txn_mem,
  output logic [63:0] txn_addr
);
  initial begin
    txn_valid = 1'b0;
    txn_mem = 1'b0;
    txn_addr = 64'h0;
  end
  // gap + 1 clock edges pass first to mimic a slow requester
  task automatic issue(input logic mem, input logic [63:0] addr, input int gap);
    repeat (gap + 1) @(posedge clk_sys);
    txn_valid <= 1'b1;
    txn_mem <= mem;
    txn_addr <= addr;
    @(posedge clk_sys);
    txn_valid <= 1'b0;
    txn_mem <= ~mem;
    // released lines show the inverse, never a stale copy
    txn_addr <= ~addr;
  endtask : issue
endmodule : txn_source_model

/* File: tb/test_bridge_memory_window_decode.sv */
`timescale 1ns/1ps
`include "bridge_window_params.svh"
// ----
// bench top
// ----
module test_bridge_memory_window_decode;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cfg_wr_en = 1'b0;
  logic cfg_rd_en = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_byte_en = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] cfg_rdata;
  logic cfg_ack, cfg_claim, txn_valid, txn_mem, dec_valid, dec_forward, dec_mem_hit, dec_pref_hit;
  logic [63:0] txn_addr;
  int fail_count = 0;
  int cmp_count = 0;
  always #10 clk_sys = ~clk_sys;
  bridge_memory_window_decode #(.ADDR_W(64)) u_bridge_memory_window_decode (.clk_sys(clk_sys), .reset_n(reset_n),
    .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .cfg_claim(cfg_claim), .txn_valid(txn_valid),
    .txn_mem(txn_mem), .txn_addr(txn_addr), .dec_valid(dec_valid), .dec_forward(dec_forward),
    .dec_mem_hit(dec_mem_hit), .dec_pref_hit(dec_pref_hit));
  txn_source_model u_txn_source_model (.clk_sys(clk_sys), .txn_valid(txn_valid), .txn_mem(txn_mem),
    .txn_addr(txn_addr));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cfg(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, input logic [31:0] exp);
    @(posedge clk_sys);
    cfg_wr_en <= wr;
    cfg_rd_en <= ~wr;
    cfg_addr <= addr;
    cfg_byte_en <= wr ? wdata[3:0] : 4'h0;
    cfg_wdata <= wdata;
    @(posedge clk_sys);
    cfg_wr_en <= 1'b0;
    cfg_rd_en <= 1'b0;
    #1;
    check({63'h0, cfg_ack}, 64'h1);
    if (!wr) check({32'h0, cfg_rdata}, {32'h0, exp});
  endtask : cfg
  // write lanes ride in wdata[3:0], which the fields never store
  task automatic txn(input logic mem, input logic [63:0] addr, input logic em, input logic ep, input int gap);
    u_txn_source_model.issue(mem, addr, gap);
    #1;
    check({60'h0, dec_valid, dec_forward, dec_mem_hit, dec_pref_hit}, {60'h0, 1'b1, em | ep, em, ep});
  endtask : txn
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    cfg(1'b0, `MEM_BOTTOM_OFS, 32'h0, 32'h0000_0000);
    cfg(1'b0, `PREF_BOTTOM_OFS, 32'h0, 32'h0001_0001);
    cfg(1'b0, `PREF_BASE_HIGH_OFS, 32'h0, 32'h0000_0000);
    cfg(1'b0, `PREF_TOP_HIGH_OFS, 32'h0, 32'h0000_0000);
    cfg(1'b0, 8'h30, 32'h0, 32'h0000_0000);
    txn(1'b1, 64'h000f_ffff, 1'b1, 1'b1, 0);
    cfg(1'b1, `MEM_BOTTOM_OFS, 32'hffff_ffff, 32'h0);
    cfg(1'b0, `MEM_BOTTOM_OFS, 32'h0, 32'hfff0_fff0);
    cfg(1'b1, `PREF_BOTTOM_OFS, 32'hffff_ffff, 32'h0);
    cfg(1'b0, `PREF_BOTTOM_OFS, 32'h0, 32'hfff1_fff1);
    cfg(1'b1, `PREF_BASE_HIGH_OFS, 32'ha5a5_a5a5, 32'h0);
    cfg(1'b0, `PREF_BASE_HIGH_OFS, 32'h0, 32'h00a5_00a5);
    cfg(1'b1, `MEM_BOTTOM_OFS, 32'h1240_123f, 32'h0);
    cfg(1'b1, `PREF_BOTTOM_OFS, 32'h8001_800f, 32'h0);
    cfg(1'b1, `PREF_BASE_HIGH_OFS, 32'h0000_000f, 32'h0);
    cfg(1'b1, `PREF_TOP_HIGH_OFS, 32'h0000_000f, 32'h0);
    txn(1'b1, 64'h1230_0000, 1'b1, 1'b0, 0);
    txn(1'b1, 64'h122f_ffff, 1'b0, 1'b0, 0);
    txn(1'b1, 64'h124f_ffff, 1'b1, 1'b0, 0);
    txn(1'b1, 64'h1250_0000, 1'b0, 1'b0, 0);
    txn(1'b0, 64'h1230_0000, 1'b0, 1'b0, 0);
    // upper words both hold 0000_000f, so the window sits at f_8000_0000
    txn(1'b1, 64'hf_8000_0000, 1'b0, 1'b1, 0);
    txn(1'b1, 64'hf_800f_ffff, 1'b0, 1'b1, 0);
    txn(1'b1, 64'hf_8010_0000, 1'b0, 1'b0, 0);
    txn(1'b1, 64'h0_8000_0000, 1'b0, 1'b0, 0);
    // base upper word above the limit upper word inverts the window
    cfg(1'b1, `PREF_BASE_HIGH_OFS, 32'h0000_001f, 32'h0);
    txn(1'b1, 64'hf_8000_0000, 1'b0, 1'b0, 0);
    cfg(1'b1, `MEM_BOTTOM_OFS, 32'h1220_123f, 32'h0);
    txn(1'b1, 64'h1230_0000, 1'b0, 1'b0, 3);
    results();
  end
endmodule : test_bridge_memory_window_decode
